/* rtl/plc_pkg.sv */
// package for the progressive lubrication cycle controller
package plc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CFG    = 8'h00; // mode bits
  localparam logic [7:0] ADDR_INTR   = 8'h04; // interruption_setting
  localparam logic [7:0] ADDR_OPTIME = 8'h08; // operating_time_limit
  localparam logic [7:0] ADDR_EDGES  = 8'h0C; // edge_target_setting
  localparam logic [7:0] ADDR_STATUS = 8'h10; // state, error, flags
  localparam logic [7:0] ADDR_COUNT  = 8'h14; // live counters

  // ---------------------------------------------------------------
  // field positions of the config word
  // ---------------------------------------------------------------
  localparam int CFG_START_BIT = 0; // start_cycle_select
  localparam int CFG_KIND_BIT  = 1; // interruption_kind
  localparam int CFG_LVLEN_BIT = 2; // level_enable
  localparam int CFG_LVLPO_BIT = 3; // level_polarity

  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [13:0] RST_INTR    = 14'h0001;
  localparam logic [13:0] RST_OPTIME  = 14'h0001;
  localparam logic [3:0]  RST_EDGES   = 4'h3;
  localparam logic [3:0]  PAUSE_EDGE_MAX = 4'h9; // more is an error
  localparam logic [15:0] SHOW_VALUE  = 16'h7FFF; // 32767
  localparam logic [5:0]  SEC_PER_MIN = 6'h3C;    // 60
  localparam logic [5:0]  EDIT_IDLE_SEC = 6'h3C;  // one minute

  // ---------------------------------------------------------------
  // timing: clock rate and printed times
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 40_000_000;
  localparam int RST_PULSE_MS  = 10;
  localparam int RST_PULSE_CYC = (CLK_HZ / 1000) * RST_PULSE_MS;
  localparam int SEC_CYC       = CLK_HZ;

  // ---------------------------------------------------------------
  // error numbers
  // ---------------------------------------------------------------
  localparam logic [3:0] ERR_NONE    = 4'h0;
  localparam logic [3:0] ERR_FEW     = 4'h1; // too few edges in time
  localparam logic [3:0] ERR_EXTRA   = 4'h2; // edges during interruption
  localparam logic [3:0] ERR_LEVEL   = 4'h3; // lack of lubricant

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        start_sel;
    logic        kind;
    logic        lvl_en;
    logic        lvl_pol;
    logic [13:0] intr_set;
    logic [13:0] op_limit;
    logic [3:0]  edge_target;
  } plc_prm_type;

  typedef struct packed {
    logic pump;
    logic pump_b;
    logic healthy;
  } plc_relay_type;

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b001,
    SQ_LUBE  = 3'b010,
    SQ_PAUSE = 3'b100
  } plc_seq_type;

  typedef enum logic [3:0] {
    ED_RUN  = 4'b0001,
    ED_PWD  = 4'b0010,
    ED_SHOW = 4'b0100,
    ED_EDIT = 4'b1000
  } plc_edit_type;

endpackage : plc_pkg

/* rtl/plc_ctrl.sv */
// progressive lubrication cycle sequencer with register port
//
// Contract
// [R1] power-up starts lube or pause per start select
// [R2] healthy relay on while no error latched
// [R3] lube cycle energises both pump relays
// [R4] count cycle switch edges within operating time
// [R5] operator sets edge target 1..9, advise three; the register takes any 4-bit value 0..15
// [R6] target reached: pumps off, interruption starts
// [R7] time mode: interruption lasts setting minutes
// [R8] load mode: strokes reaching setting restart lube
// [R9] hold contact stops timer or ignores strokes
// [R10] level monitored only when level enabled
// [R11] level polarity selects normally open or closed
// [R12] error: too few edges before time limit
// [R13] error: over nine edges during interruption
// [R14] error: enabled level switch reports lack
// [R15] any error drops all three relays
// [R16] error indication carries error number
// [R17] error held until power, key five, reset pulse
// [R18] high clear input also clears error
// [R19] reset pulse without error adds lube cycle
// [R20] editing stops control; key one leaves editing
// [R21] not ready until parameterisation completed
// [R22] key zero, password shows 32767; key two edits
// [R23] one minute without key abandons editing
// [R24] inputs synchronised, debounced; second, minute ticks
// [R25] edge counter clears at each cycle start
`timescale 1ns/1ps
`default_nettype none

module plc_ctrl
  import plc_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int RST_CYCLES = RST_PULSE_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata_ff,
  // field pins
  input  wire logic        stroke_input,
  input  wire logic        cycle_switch_input,
  input  wire logic        level_input,
  input  wire logic        pause_hold_input,
  input  wire logic        reset_input,
  input  wire logic        clear_input,
  // key events from the key scanner, one cycle each
  input  wire logic        key0,
  input  wire logic        key1,
  input  wire logic        key2,
  input  wire logic        key5,
  input  wire logic        pwd_ok,
  input  wire logic        pwd_bad,
  // relays and indication
  output var  logic        pump_relay_ff,
  output var  logic        pump_relay_b_ff,
  output var  logic        healthy_relay_ff,
  output var  logic        error_ff,
  output var  logic [3:0]  error_num_ff,
  output var  logic        ready_ff,
  output var  logic [15:0] disp_value_ff
);

  // ---------------------------------------------------------------
  // input synchronisers and filters
  // ---------------------------------------------------------------
  localparam int NIN = 6;
  logic [NIN-1:0] pin_raw;
  logic [NIN-1:0] filt_ff;
  logic [NIN-1:0] filt_d_ff;

  assign pin_raw = {clear_input, reset_input, pause_hold_input,
                    level_input, cycle_switch_input, stroke_input};

  // three stages; level changes once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      logic [2:0] sync_ff;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sync_ff <= 3'h0;
          filt_ff[gi] <= 1'b0;
          filt_d_ff[gi] <= 1'b0;
        end else begin
          sync_ff <= {sync_ff[1:0], pin_raw[gi]};
          filt_d_ff[gi] <= filt_ff[gi]; // previous level for edges
          if (sync_ff[1] == sync_ff[2]) begin
            filt_ff[gi] <= sync_ff[2]; // R24
          end
        end
      end
    end
  endgenerate

  wire stroke_rise = filt_ff[0] & ~filt_d_ff[0];
  wire cyc_edge    = filt_ff[1] ^ filt_d_ff[1];  // both edges count
  wire level_lvl   = filt_ff[2];
  wire hold_lvl    = filt_ff[3];
  wire rstin_lvl   = filt_ff[4];
  wire rstin_fall  = ~filt_ff[4] & filt_d_ff[4];
  wire clear_lvl   = filt_ff[5];

  // ---------------------------------------------------------------
  // second tick prescaler
  // ---------------------------------------------------------------
  localparam int SECW = $clog2(SEC_CYCLES + 1);
  localparam logic [SECW-1:0] SEC_LAST = SECW'(SEC_CYCLES - 1);
  logic [SECW-1:0] sec_pre_ff;
  wire sec_tick = (sec_pre_ff == SEC_LAST);

  always_ff @(posedge clk) begin
    if (!rst_n || sec_tick) begin
      sec_pre_ff <= '0; // R24
    end else begin
      sec_pre_ff <= sec_pre_ff + SECW'(1);
    end
  end

  // ---------------------------------------------------------------
  // reset input pulse width measurement
  // ---------------------------------------------------------------
  localparam int RSTW = $clog2(RST_CYCLES + 1);
  localparam logic [RSTW-1:0] RST_MIN = RSTW'(RST_CYCLES);
  logic [RSTW-1:0] rst_len_ff;
  wire rst_pulse = rstin_fall & (rst_len_ff >= RST_MIN); // R17

  always_ff @(posedge clk) begin
    if (!rst_n || !rstin_lvl) begin
      rst_len_ff <= '0;
    end else if (rst_len_ff != RST_MIN) begin
      rst_len_ff <= rst_len_ff + RSTW'(1);
    end
  end

  // ---------------------------------------------------------------
  // parameter editing sequence
  // ---------------------------------------------------------------
  plc_edit_type ed_ff;
  plc_edit_type nxt_ed;
  logic [5:0]   idle_sec_ff;
  logic         cfg_done_ff;
  wire any_key  = key0 | key1 | key2 | key5;
  wire editing  = (ed_ff == ED_EDIT);
  wire edit_to  = editing & (idle_sec_ff == EDIT_IDLE_SEC);

  // key zero opens password; key two enters editing
  always_comb begin
    nxt_ed = ed_ff;
    unique case (ed_ff)
      ED_RUN:  if (key0) nxt_ed = ED_PWD;
      ED_PWD:  nxt_ed = pwd_ok ? ED_SHOW : pwd_bad ? ED_RUN : ED_PWD; // R22
      ED_SHOW: nxt_ed = key2 ? ED_EDIT : key1 ? ED_RUN : ED_SHOW; // R22
      ED_EDIT: nxt_ed = key1 ? ED_RUN : edit_to ? ED_PWD : ED_EDIT; // R20 R23
      default: nxt_ed = ED_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ed_ff <= ED_RUN;
    end else begin
      ed_ff <= nxt_ed;
    end
  end

  // idle seconds in editing; any key restarts the minute
  always_ff @(posedge clk) begin
    if (!rst_n || !editing || any_key) begin
      idle_sec_ff <= 6'h00;
    end else if (sec_tick && idle_sec_ff != EDIT_IDLE_SEC) begin
      idle_sec_ff <= idle_sec_ff + 6'h01; // R23
    end
  end

  // completed parameterisation arms operation
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_done_ff <= 1'b0;
    end else if (editing && key1) begin
      cfg_done_ff <= 1'b1; // R21
    end
  end

  wire run_ok = cfg_done_ff & ~editing; // R20 R21

  // ---------------------------------------------------------------
  // parameter registers, written only while editing
  // ---------------------------------------------------------------
  plc_prm_type prm_ff;
  wire wr_ok = reg_wr & editing;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prm_ff <= '{start_sel: 1'b0, kind: 1'b0, lvl_en: 1'b0,
                  lvl_pol: 1'b0, intr_set: RST_INTR,
                  op_limit: RST_OPTIME, edge_target: RST_EDGES};
    end else if (wr_ok) begin
      if (reg_addr == ADDR_CFG) begin
        prm_ff.start_sel <= reg_wdata[CFG_START_BIT];
        prm_ff.kind      <= reg_wdata[CFG_KIND_BIT];
        prm_ff.lvl_en    <= reg_wdata[CFG_LVLEN_BIT];
        prm_ff.lvl_pol   <= reg_wdata[CFG_LVLPO_BIT];
      end
      if (reg_addr == ADDR_INTR) prm_ff.intr_set <= reg_wdata[13:0];
      if (reg_addr == ADDR_OPTIME) prm_ff.op_limit <= reg_wdata[13:0];
      if (reg_addr == ADDR_EDGES) prm_ff.edge_target <= reg_wdata[3:0]; // R5
    end
  end

  // ---------------------------------------------------------------
  // error detection and latch
  // ---------------------------------------------------------------
  plc_seq_type sq_ff;
  plc_seq_type nxt_sq;
  logic [3:0]  edge_cnt_ff;
  logic [13:0] op_sec_ff;
  logic [13:0] ev_cnt_ff;
  logic [5:0]  min_sec_ff;
  logic [3:0]  err_code_ff;

  wire lube    = (sq_ff == SQ_LUBE);
  wire pausing = (sq_ff == SQ_PAUSE);
  wire lack    = prm_ff.lvl_pol ? level_lvl : ~level_lvl; // R11
  wire err_lvl = run_ok & prm_ff.lvl_en & lack;           // R10 R14
  wire err_few = lube & (op_sec_ff >= prm_ff.op_limit)
               & (edge_cnt_ff < prm_ff.edge_target);      // R12
  wire err_xtr = pausing & (edge_cnt_ff > PAUSE_EDGE_MAX); // R13
  wire err_new = err_few | err_xtr | err_lvl;
  wire err_clr = key5 | rst_pulse | clear_lvl;            // R17 R18
  wire err_on  = (err_code_ff != ERR_NONE);

  // first error's number is kept; a new error beats a clear
  wire [3:0] err_sel      = err_few ? ERR_FEW :
                            err_xtr ? ERR_EXTRA : ERR_LEVEL;
  wire       err_load     = err_new & (~err_on | err_clr);
  wire [3:0] nxt_err_code = err_load ? err_sel :               // R16
                            err_clr  ? ERR_NONE : err_code_ff; // R17 R18
  // healthy relay, error flag and error number follow this one next value
  wire       err_next_on  = (nxt_err_code != ERR_NONE);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      err_code_ff <= ERR_NONE;
    end else begin
      err_code_ff <= nxt_err_code;
    end
  end

  // ---------------------------------------------------------------
  // cycle sequencer
  // ---------------------------------------------------------------
  wire edges_done = (edge_cnt_ff >= prm_ff.edge_target);
  wire intr_done  = (ev_cnt_ff >= prm_ff.intr_set);
  wire extra_lube = rst_pulse & ~err_on;                   // R19
  wire first_lube = prm_ff.start_sel;                      // R1

  always_comb begin
    nxt_sq = sq_ff;
    unique case (sq_ff)
      SQ_IDLE: begin
        if (run_ok && !err_on) begin
          nxt_sq = first_lube ? SQ_LUBE : SQ_PAUSE; // R1
        end
      end
      SQ_LUBE:  if (edges_done) nxt_sq = SQ_PAUSE; // R6
      SQ_PAUSE: if (intr_done || extra_lube) nxt_sq = SQ_LUBE; // R7 R8 R19
      default: nxt_sq = SQ_IDLE;
    endcase
    if (!run_ok || err_on || err_new) begin
      nxt_sq = SQ_IDLE; // R15 R20
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sq_ff <= SQ_IDLE;
    end else begin
      sq_ff <= nxt_sq;
    end
  end

  wire entering = (nxt_sq != sq_ff);

  // edge counter cleared on every cycle change
  always_ff @(posedge clk) begin
    if (!rst_n || entering) begin
      edge_cnt_ff <= 4'h0; // R25
    end else if (cyc_edge && (lube || pausing)
                 && edge_cnt_ff != 4'hF) begin
      edge_cnt_ff <= edge_cnt_ff + 4'h1; // R4 R13
    end
  end

  // operating seconds during lubrication
  always_ff @(posedge clk) begin
    if (!rst_n || !lube || entering) begin
      op_sec_ff <= 14'h0000;
    end else if (sec_tick && op_sec_ff != 14'h3FFF) begin
      op_sec_ff <= op_sec_ff + 14'h0001; // R4
    end
  end

  // minute builder during timed interruption, halted by hold
  wire min_run  = pausing & prm_ff.kind & ~hold_lvl;       // R9
  wire min_tick = min_run & sec_tick
                & (min_sec_ff == SEC_PER_MIN - 6'h01);

  always_ff @(posedge clk) begin
    if (!rst_n || !pausing || entering || min_tick) begin
      min_sec_ff <= 6'h00;
    end else if (min_run && sec_tick) begin
      min_sec_ff <= min_sec_ff + 6'h01; // R24
    end
  end

  // interruption events: minutes or machine strokes
  wire stroke_ok = pausing & ~prm_ff.kind & ~hold_lvl & stroke_rise; // R8 R9
  wire ev_step   = prm_ff.kind ? min_tick : stroke_ok;  // R7 R8

  always_ff @(posedge clk) begin
    if (!rst_n || !pausing || entering) begin
      ev_cnt_ff <= 14'h0000;
    end else if (ev_step && ev_cnt_ff != 14'h3FFF) begin
      ev_cnt_ff <= ev_cnt_ff + 14'h0001;
    end
  end

  // ---------------------------------------------------------------
  // relay and indication outputs
  // ---------------------------------------------------------------
  plc_relay_type nxt_rly;
  wire relay_lube = (nxt_sq == SQ_LUBE);

  assign nxt_rly.pump    = relay_lube;                  // R3 R6 R15
  assign nxt_rly.pump_b  = relay_lube;                  // R3 R6 R15
  assign nxt_rly.healthy = ~err_next_on;                // R2 R15

  wire [15:0] nxt_disp = (ed_ff == ED_SHOW) ? SHOW_VALUE :
                         {12'h000, err_code_ff};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pump_relay_ff    <= 1'b0;
      pump_relay_b_ff  <= 1'b0;
      healthy_relay_ff <= 1'b1; // R2
      error_ff         <= 1'b0;
      error_num_ff     <= ERR_NONE;
      ready_ff         <= 1'b0;
      disp_value_ff    <= 16'h0000;
    end else begin
      pump_relay_ff    <= nxt_rly.pump;
      pump_relay_b_ff  <= nxt_rly.pump_b;
      healthy_relay_ff <= nxt_rly.healthy;
      error_ff         <= err_next_on;   // R16
      error_num_ff     <= nxt_err_code;  // R16
      ready_ff         <= run_ok;        // R21
      disp_value_ff    <= nxt_disp;      // R22
    end
  end

  // ---------------------------------------------------------------
  // register read, data in the cycle after the strobe
  // ---------------------------------------------------------------
  wire [31:0] rd_cfg = {28'h0, prm_ff.lvl_pol, prm_ff.lvl_en,
                        prm_ff.kind, prm_ff.start_sel};
  wire [31:0] rd_sts = {17'h0, ed_ff, err_code_ff, cfg_done_ff,
                        err_on, sq_ff, hold_lvl, lack};
  wire [31:0] rd_cnt = {4'h0, op_sec_ff, ev_cnt_ff[9:0], edge_cnt_ff};
  wire [31:0] rd_mux = (reg_addr == ADDR_CFG)    ? rd_cfg :
                       (reg_addr == ADDR_INTR)   ? {18'h0, prm_ff.intr_set} :
                       (reg_addr == ADDR_OPTIME) ? {18'h0, prm_ff.op_limit} :
                       (reg_addr == ADDR_EDGES)  ? {28'h0, prm_ff.edge_target} :
                       (reg_addr == ADDR_STATUS) ? rd_sts :
                       (reg_addr == ADDR_COUNT)  ? rd_cnt : 32'h0;

  always_ff @(posedge clk) begin
    if (!rst_n || !reg_rd) begin
      reg_rdata_ff <= 32'h0;
    end else begin
      reg_rdata_ff <= rd_mux;
    end
  end

endmodule : plc_ctrl

`default_nettype wire

/* testbench/plc_props.sv */
// assertion checker on the lubrication cycle controller ports
`timescale 1ns/1ps
`default_nettype none

module plc_props
  import plc_pkg::*;
#(
  parameter int SEC_CYCLES = 20,
  parameter int RST_CYCLES = 8
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata_ff,
  // key events
  input wire logic        key0,
  input wire logic        key1,
  input wire logic        pwd_ok,
  input wire logic        pwd_bad,
  // relays and indication
  input wire logic        pump_relay_ff,
  input wire logic        pump_relay_b_ff,
  input wire logic        healthy_relay_ff,
  input wire logic        error_ff,
  input wire logic [3:0]  error_num_ff,
  input wire logic        ready_ff,
  input wire logic [15:0] disp_value_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // relays, error, readiness and display
  pump_pair_a: assert property (pump_relay_ff == pump_relay_b_ff)
    else $error("pump relays differ");
  err_relays_a: assert property (error_ff [*3] |->
    !pump_relay_ff && !pump_relay_b_ff && !healthy_relay_ff)
    else $error("relay held during error");
  healthy_ok_a: assert property (!error_ff [*3] |-> healthy_relay_ff)
    else $error("healthy relay low without error");
  err_num_a: assert property (error_ff [*2] |->
    error_num_ff inside {ERR_FEW, ERR_EXTRA, ERR_LEVEL})
    else $error("bad error number");
  not_ready_a: assert property (!ready_ff [*8] |-> !pump_relay_ff)
    else $error("pump runs while not ready");
  ready_rise_a: assert property ($rose(ready_ff) |->
    $past(key1) || $past(key1, 2) || $past(key1, 3) || $past(pwd_bad, 2))
    else $error("ready rose without leaving editing");
  show_a: assert property (key0 ##1 pwd_ok |->
    ##[1:3] disp_value_ff == SHOW_VALUE)
    else $error("accepted password not shown");

  // register port read data
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == '0)
    else $error("read data outside read answer");
  unmapped_a: assert property ($past(reg_rd) &&
    $past(reg_addr) > ADDR_COUNT |-> reg_rdata_ff == '0)
    else $error("unmapped read not zero");
endmodule : plc_props

`default_nettype wire

/* testbench/plc_field_model.sv */
// field model: pump with distributor cycle switch
`timescale 1ns/1ps
`default_nettype none

module plc_field_model #(
  parameter int GAP = 6
) (
  // clock
  input  wire logic clk,
  // commands
  input  wire logic pump_on,
  input  wire logic stall,
  input  wire logic chatter,
  // cycle switch contact
  output var  logic cyc_sw
);
  int cnt;

  initial begin
    cnt = 0;
    cyc_sw = 1'h0;
  end

  // piston moves while the pump runs, stuck when stalled unless chatter is set
  always @(posedge clk) begin
    if ((pump_on && !stall) || chatter) begin
      cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
      if (cnt == GAP - 1) cyc_sw <= ~cyc_sw;
    end
  end
endmodule : plc_field_model

`default_nettype wire

/* testbench/progressive_lube_cycle_ctrl_tb_top.sv */
// testbench top for the lubrication cycle controller
`timescale 1ns/1ps
`default_nettype none

module progressive_lube_cycle_ctrl_tb_top
  import plc_pkg::*;
;
  logic        clk = 1'h0;
  logic        rst_n = 1'h0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [5:0]  keys = 6'h00;
  logic        stroke = 1'h0, level = 1'h0, hold = 1'h0;
  logic        rst_in = 1'h0, clr = 1'h0, stall = 1'h0, chatter = 1'h0;
  logic [31:0] rdata;
  logic [15:0] disp;
  logic [3:0]  err_num;
  logic        pump, pump_b, healthy, err, ready, cyc_sw;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;

  plc_ctrl #(.SEC_CYCLES(20), .RST_CYCLES(8)) dut (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
    .stroke_input(stroke), .cycle_switch_input(cyc_sw),
    .level_input(level), .pause_hold_input(hold),
    .reset_input(rst_in), .clear_input(clr),
    .key0(keys[0]), .key1(keys[1]), .key2(keys[2]), .key5(keys[3]),
    .pwd_ok(keys[4]), .pwd_bad(keys[5]),
    .pump_relay_ff(pump), .pump_relay_b_ff(pump_b),
    .healthy_relay_ff(healthy), .error_ff(err), .error_num_ff(err_num),
    .ready_ff(ready), .disp_value_ff(disp));

  plc_field_model #(.GAP(6)) field (.clk(clk), .pump_on(pump),
    .stall(stall), .chatter(chatter), .cyc_sw(cyc_sw));

  // clock and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  // bounded wait at falling edges, then compare
  task automatic wait_for(ref logic s, input logic v, input int n);
    int i;
    i = 0;
    @(negedge clk);
    while (s !== v && i < n) begin
      @(negedge clk);
      i++;
    end
    chk(s, v);
  endtask : wait_for

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(negedge clk);
    chk(rdata, exp);
  endtask : rd

  task automatic key(input logic [5:0] k);
    @(posedge clk);
    keys <= k;
  endtask : key

  task automatic strokes(input int n);
    repeat (n) begin
      tick(1);
      stroke <= 1'h1;
      tick(4);
      stroke <= 1'h0;
      tick(4);
    end
  endtask : strokes

  task automatic pulse_reset();
    tick(1);
    rst_in <= 1'h1;
    tick(12);
    rst_in <= 1'h0;
  endtask : pulse_reset

  // password, editing, configuration, leave editing
  task automatic setup(input logic [31:0] cfg, input logic [31:0] intr);
    key(6'h01);
    key(6'h10);
    key(6'h00);
    tick(3);
    @(negedge clk);
    chk(disp, SHOW_VALUE);
    key(6'h04);
    key(6'h00);
    wr(ADDR_CFG, cfg);
    wr(ADDR_INTR, intr);
    wr(ADDR_OPTIME, 32'h3);
    wr(ADDR_EDGES, 32'h3);
    rd(ADDR_CFG, cfg);
    rd(ADDR_INTR, intr);
    rd(8'h40, 32'h0);
    key(6'h02);
    key(6'h00);
    wait_for(ready, 1'h1, 6);
  endtask : setup

  task automatic lube();
    wait_for(pump, 1'h1, 40);
    chk(pump_b, 1'h1);
    wait_for(pump, 1'h0, 80);
    chk(healthy, 1'h1);
  endtask : lube

  task automatic t_load();
    tick(1);
    hold <= 1'h1;
    strokes(3);
    wait_for(pump, 1'h0, 1);
    tick(1);
    hold <= 1'h0;
    tick(8);
    strokes(2);
    lube();
  endtask : t_load

  task automatic t_few();
    tick(1);
    stall <= 1'h1;
    strokes(2);
    wait_for(err, 1'h1, 200);
    chk(err_num, ERR_FEW);
    wait_for(healthy, 1'h0, 2);
    chk(pump, 1'h0);
    tick(1);
    stall <= 1'h0;
    clr <= 1'h1;
    tick(4);
    clr <= 1'h0;
    wait_for(err, 1'h0, 20);
    lube();
  endtask : t_few

  task automatic t_extra();
    tick(1);
    chatter <= 1'h1;
    wait_for(err, 1'h1, 150);
    chk(err_num, ERR_EXTRA);
    tick(1);
    chatter <= 1'h0;
    pulse_reset();
    wait_for(err, 1'h0, 20);
    lube();
  endtask : t_extra

  task automatic t_level();
    tick(1);
    level <= 1'h1;
    wait_for(err, 1'h1, 20);
    chk(err_num, ERR_LEVEL);
    tick(1);
    level <= 1'h0;
    tick(10);
    key(6'h08);
    key(6'h00);
    wait_for(err, 1'h0, 10);
    lube();
  endtask : t_level

  task automatic t_time();
    setup(32'h0000_000B, 32'h1);
    tick(1);
    level <= 1'h1;
    lube();
    tick(1000);
    wait_for(pump, 1'h0, 1);
    wait_for(pump, 1'h1, 400);
    chk(err, 1'h0);
  endtask : t_time

  // main sequence
  initial begin
    tick(16);
    rst_n <= 1'h1;
    @(negedge clk);
    chk(healthy, 1'h1);
    chk(pump, 1'h0);
    setup(32'h0000_000D, 32'h2);
    lube();
    t_load();
    t_few();
    t_extra();
    tick(20);
    pulse_reset();
    lube();
    t_level();
    t_time();
    give_verdict();
  end
endmodule : progressive_lube_cycle_ctrl_tb_top

bind plc_ctrl plc_props #(.SEC_CYCLES(SEC_CYCLES), .RST_CYCLES(RST_CYCLES))
  u_props (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata_ff(reg_rdata_ff), .key0(key0), .key1(key1), .pwd_ok(pwd_ok),
  .pwd_bad(pwd_bad), .pump_relay_ff(pump_relay_ff),
  .pump_relay_b_ff(pump_relay_b_ff), .healthy_relay_ff(healthy_relay_ff),
  .error_ff(error_ff), .error_num_ff(error_num_ff), .ready_ff(ready_ff),
  .disp_value_ff(disp_value_ff));

`default_nettype wire
